/* File: design/trace_pkg.sv */
// constants, types and record layout for the software trace debug port
// assumes a single 125 MHz core clock and a probe on the low pin count link
//
// What this block does
// - a program-counter trace instruction emits one record holding the current program counter.
// - a tag trace instruction emits a record with its 10-bit immediate, with the pc optionally.
// - records go into the internal trace memory and are then sent over the debug link pins.
// - with no probe connected the trace instructions drive nothing on the link pins.
// - on the four-pin link a pc record takes 57 link clocks, a tag-only record 19.
// - on the one-pin link a pc or single-register record takes 57 bits (76 for a register record with pc), a tag-only record 19.
// - the trace buffer absorbs bursts and records are lost once seven of its eight stages are in use.
// - bits 30 and 29 of option word zero pick four-pin (01), one-pin (10) or boundary scan (11).
// - a data-qualified access break acts after the instruction, other access breaks before it.
// - each record takes one buffer stage, and with seven filled an overflow marker goes in the eighth.

package trace_pkg;

	// clock and link timing
	localparam int CLK_NS       = 8;
	localparam int LINK4_KHZ    = 11000;
	localparam int TX4_LONG_NS  = 5182;
	localparam int TX4_SHORT_NS = 1727;
	localparam int TX1_LONG_NS  = 28500;
	localparam int TX1_SHORT_NS = 9500;
	localparam int BIT1_NS      = 500;
	localparam int SYMS_LONG    = (TX4_LONG_NS * LINK4_KHZ + 500000) / 1000000;
	localparam int SYMS_SHORT   = (TX4_SHORT_NS * LINK4_KHZ + 500000) / 1000000;
	localparam int SYMS_1_LONG  = TX1_LONG_NS / BIT1_NS;
	localparam int SYMS_1_SHORT = TX1_SHORT_NS / BIT1_NS;
	localparam int SYMS_1_WIDE  = 76;
	localparam int BIT1_CYC     = (BIT1_NS / CLK_NS < 1) ? 1 : BIT1_NS / CLK_NS;

	// option word zero interface select field
	localparam int          SEL_HI_POS = 30;
	localparam int          SEL_LO_POS = 29;
	localparam logic [1:0]  SEL_FOUR   = 2'h1;
	localparam logic [1:0]  SEL_ONE    = 2'h2;
	localparam logic [1:0]  SEL_SCAN   = 2'h3;
	localparam logic [1:0]  SEL_RESET  = 2'h3;

	// trace buffer
	localparam int          BUF_DEPTH  = 8;
	localparam logic [3:0]  BUF_OVF_AT = 4'h7;
	localparam logic [3:0]  BUF_FULL   = 4'h8;
	localparam int          REC_BITS   = 72;

	typedef enum logic [1:0] {kind_pc, kind_tag, kind_regs, kind_ovf} rec_kind_type;

	// request from the core when a trace instruction executes
	typedef struct packed {
		logic         valid;
		rec_kind_type kind;
		logic         with_pc;
		logic [31:0]  pc;
		logic [9:0]   tag_immediate;
		logic [4:0]   first_dump_reg;
		logic [4:0]   last_dump_reg;
	} trace_req_type;

	// one buffer stage
	typedef struct packed {
		rec_kind_type kind;
		logic         with_pc;
		logic [4:0]   reg_num;
		logic [31:0]  value;
		logic [31:0]  pc;
	} trace_rec_type;

	// break request from the access comparators
	typedef struct packed {
		logic hit;
		logic data_qual;
		logic instr_done;
	} brk_in_type;

endpackage

/* File: design/trace_fifo.sv */
// trace buffer: small synchronous fifo with valid and ready on both sides
// assumes one clock and reader and writer in that domain
`timescale 1ns/100ps
`default_nettype none

module trace_fifo #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [CW-1:0]    cnt_r, cnt_nxt;
	logic             wr_en, rd_en;

	// honest full and empty from the stage count
	assign in_ready  = (cnt_r != CW'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
	assign count     = cnt_r;
	assign wr_en     = in_valid & in_ready;
	assign rd_en     = out_valid & out_ready;

	// pointer and count next values
	always_comb begin
		wr_nxt  = wr_en ? PW'(wr_r + 1'b1) : wr_r;
		rd_nxt  = rd_en ? PW'(rd_r + 1'b1) : rd_r;
		cnt_nxt = cnt_r;
		if (wr_en && !rd_en) begin
			cnt_nxt = CW'(cnt_r + 1'b1);
		end else if (rd_en && !wr_en) begin
			cnt_nxt = CW'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage stages, no reset needed
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_r[wr_r] <= in_data;
		end
	end

endmodule
`default_nettype wire

/* File: design/sw_trace_port.sv */
// software trace debug port: trace records, trace buffer, link serializer, break timing
// assumes core signals on clk; probe pins and link clock arrive asynchronously
`timescale 1ns/100ps
`default_nettype none

module sw_trace_port (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire trace_pkg::trace_req_type trace_req,
	output logic                          trace_ready_r,
	output logic [4:0]                    reg_rd_idx_r,
	input  wire logic [31:0]              reg_rd_data,
	input  wire logic [31:0]              option_word_zero,
	input  wire logic                     probe_present,
	input  wire logic                     link_clk,
	output logic [3:0]                    lpd_data_r,
	output logic                          lpd_data_oe_r,
	output logic                          lpd_dio_r,
	output logic                          lpd_dio_oe_r,
	output logic                          trace_lost_r,
	input  wire trace_pkg::brk_in_type    brk_in,
	output logic                          break_before_r,
	output logic                          break_after_r
);
	typedef enum logic {st_idle, st_dump} dump_st_type;

	// frame content: header then body, msb first
	function automatic logic [71:0] frame_bits(input trace_pkg::trace_rec_type r);
		logic [7:0] hdr;
		hdr = {r.kind, r.with_pc, r.reg_num};
		case (r.kind)
			trace_pkg::kind_tag:  frame_bits = {hdr, r.value[9:0], r.pc, 22'h0};
			trace_pkg::kind_pc:   frame_bits = {hdr, r.pc, 32'h0};
			trace_pkg::kind_regs: frame_bits = {hdr, r.value, r.pc};
			default:              frame_bits = {hdr, 64'h0};
		endcase
	endfunction

	// symbols per frame for the selected link
	function automatic logic [6:0] frame_len(input trace_pkg::trace_rec_type r, input logic one);
		logic short_f;
		short_f = (r.kind == trace_pkg::kind_ovf) ||
			(r.kind == trace_pkg::kind_tag && !r.with_pc);
		if (short_f) begin
			frame_len = one ? 7'(trace_pkg::SYMS_1_SHORT) : 7'(trace_pkg::SYMS_SHORT);
		end else if (one && r.kind == trace_pkg::kind_regs && r.with_pc) begin
			frame_len = 7'(trace_pkg::SYMS_1_WIDE);
		end else begin
			frame_len = one ? 7'(trace_pkg::SYMS_1_LONG) : 7'(trace_pkg::SYMS_LONG);
		end
	endfunction

	// pin synchronisers and edge finder
	logic [1:0] probe_sync_r, probe_sync_nxt;
	logic [2:0] lclk_sync_r, lclk_sync_nxt;
	logic       lclk_rise;
	always_comb begin
		probe_sync_nxt = {probe_sync_r[0], probe_present};
		lclk_sync_nxt  = {lclk_sync_r[1:0], link_clk};
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			probe_sync_r <= 2'h0;
			lclk_sync_r  <= 3'h0;
		end else begin
			probe_sync_r <= probe_sync_nxt;
			lclk_sync_r  <= lclk_sync_nxt;
		end
	end
	assign lclk_rise = lclk_sync_r[1] & ~lclk_sync_r[2];

	// interface select caught once after reset release, later writes ignored
	logic [1:0] sel_r, sel_nxt;
	logic       sel_done_r, sel_done_nxt;
	logic       link_on, one_pin;
	always_comb begin
		sel_nxt      = sel_r;
		sel_done_nxt = 1'b1;
		if (!sel_done_r) begin
			sel_nxt = option_word_zero[trace_pkg::SEL_HI_POS:trace_pkg::SEL_LO_POS];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_r      <= trace_pkg::SEL_RESET;
			sel_done_r <= 1'b0;
		end else begin
			sel_r      <= sel_nxt;
			sel_done_r <= sel_done_nxt;
		end
	end
	// link live only with a probe and an lpd selection
	assign link_on = probe_sync_r[1] && sel_done_r &&
		(sel_r == trace_pkg::SEL_FOUR || sel_r == trace_pkg::SEL_ONE);
	assign one_pin = (sel_r == trace_pkg::SEL_ONE);

	// trace buffer
	logic                     push_r, push_nxt;
	trace_pkg::trace_rec_type push_rec_r, push_rec_nxt;
	logic                     buf_in_ready, buf_out_valid, buf_pop;
	logic [71:0]              buf_out_raw;
	trace_pkg::trace_rec_type buf_out;
	logic [3:0]               buf_count;
	trace_fifo #(
		.WIDTH (trace_pkg::REC_BITS),
		.DEPTH (trace_pkg::BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (push_r),
		.in_ready  (buf_in_ready),
		.in_data   (push_rec_r),
		.out_valid (buf_out_valid),
		.out_ready (buf_pop),
		.out_data  (buf_out_raw),
		.count     (buf_count)
	);
	assign buf_out = buf_out_raw;

	// record builder and register dump sequencer
	dump_st_type              st_r, st_nxt;
	logic [4:0]               last_r, last_nxt, idx_nxt;
	logic                     dpc_r, dpc_nxt;
	logic [31:0]              dpc_val_r, dpc_val_nxt;
	logic                     ready_nxt, lost_nxt;
	logic [3:0]               fill;
	trace_pkg::trace_rec_type cand;
	logic                     cand_ok;
	always_comb begin
		st_nxt    = st_r;
		last_nxt  = last_r;
		idx_nxt   = reg_rd_idx_r;
		dpc_nxt   = dpc_r;
		dpc_val_nxt = dpc_val_r;
		cand      = '0;
		cand_ok   = 1'b0;
		case (st_r)
			st_idle: begin
				if (trace_req.valid && trace_ready_r) begin
					cand.kind    = trace_req.kind;
					cand.with_pc = trace_req.with_pc || trace_req.kind == trace_pkg::kind_pc;
					cand.pc      = trace_req.pc;
					cand.value   = {22'h0, trace_req.tag_immediate};
					cand_ok      = (trace_req.kind != trace_pkg::kind_regs);
					if (trace_req.kind == trace_pkg::kind_regs) begin
						st_nxt      = st_dump;
						idx_nxt     = trace_req.first_dump_reg;
						last_nxt    = trace_req.last_dump_reg;
						dpc_nxt     = trace_req.with_pc;
						dpc_val_nxt = trace_req.pc;
					end
				end
			end
			st_dump: begin
				cand.kind    = trace_pkg::kind_regs;
				cand.with_pc = dpc_r;
				cand.pc      = dpc_r ? dpc_val_r : 32'h0;
				cand.reg_num = reg_rd_idx_r;
				cand.value   = reg_rd_data;
				cand_ok      = 1'b1;
				if (reg_rd_idx_r >= last_r) begin
					st_nxt = st_idle;
				end else begin
					idx_nxt = 5'(reg_rd_idx_r + 1'b1);
				end
			end
			default: st_nxt = st_idle;
		endcase
		ready_nxt = (st_nxt == st_idle);
		// stages in use including the write still in flight
		fill      = buf_count + {3'h0, push_r};
		push_nxt  = 1'b0;
		push_rec_nxt = cand;
		lost_nxt  = 1'b0;
		if (cand_ok && link_on) begin
			if (fill < trace_pkg::BUF_OVF_AT) begin
				push_nxt = 1'b1;
			end else if (fill == trace_pkg::BUF_OVF_AT) begin
				push_nxt          = 1'b1;
				push_rec_nxt      = '0;
				push_rec_nxt.kind = trace_pkg::kind_ovf;
				lost_nxt          = 1'b1;
			end else begin
				lost_nxt = 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r          <= st_idle;
			last_r        <= 5'h0;
			reg_rd_idx_r  <= 5'h0;
			dpc_r         <= 1'b0;
			dpc_val_r     <= 32'h0;
			trace_ready_r <= 1'b1;
			push_r        <= 1'b0;
			push_rec_r    <= '0;
			trace_lost_r  <= 1'b0;
		end else begin
			st_r          <= st_nxt;
			last_r        <= last_nxt;
			reg_rd_idx_r  <= idx_nxt;
			dpc_r         <= dpc_nxt;
			dpc_val_r     <= dpc_val_nxt;
			trace_ready_r <= ready_nxt;
			push_r        <= push_nxt;
			push_rec_r    <= push_rec_nxt;
			trace_lost_r  <= lost_nxt;
		end
	end

	// link serializer: nibbles on link clock edges or bits on the bit timer
	logic        busy_r, busy_nxt;
	logic [71:0] sh_r, sh_nxt;
	logic [6:0]  left_r, left_nxt;
	logic [5:0]  btmr_r, btmr_nxt;
	logic [3:0]  data_nxt;
	logic        data_oe_nxt, dio_nxt, dio_oe_nxt, tick;
	assign tick    = one_pin ? (btmr_r == 6'h0) : lclk_rise;
	assign buf_pop = !busy_r && buf_out_valid && link_on;
	always_comb begin
		busy_nxt    = busy_r;
		sh_nxt      = sh_r;
		left_nxt    = left_r;
		btmr_nxt    = (btmr_r == 6'h0) ? 6'(trace_pkg::BIT1_CYC - 1) : 6'(btmr_r - 1'b1);
		data_nxt    = lpd_data_r;
		data_oe_nxt = lpd_data_oe_r;
		dio_nxt     = lpd_dio_r;
		dio_oe_nxt  = lpd_dio_oe_r;
		if (!link_on) begin
			busy_nxt    = 1'b0;
			data_oe_nxt = 1'b0;
			dio_oe_nxt  = 1'b0;
			data_nxt    = 4'h0;
			dio_nxt     = 1'b0;
		end else if (buf_pop) begin
			busy_nxt = 1'b1;
			sh_nxt   = frame_bits(buf_out);
			left_nxt = frame_len(buf_out, one_pin);
			btmr_nxt = 6'h0;
		end else if (busy_r && tick) begin
			if (left_r == 7'h0) begin
				busy_nxt    = 1'b0;
				data_oe_nxt = 1'b0;
				dio_oe_nxt  = 1'b0;
				data_nxt    = 4'h0;
				dio_nxt     = 1'b0;
			end else if (one_pin) begin
				dio_nxt    = sh_r[71];
				dio_oe_nxt = 1'b1;
				sh_nxt     = {sh_r[70:0], 1'b0};
				left_nxt   = 7'(left_r - 1'b1);
			end else begin
				data_nxt    = sh_r[71:68];
				data_oe_nxt = 1'b1;
				sh_nxt      = {sh_r[67:0], 4'h0};
				left_nxt    = 7'(left_r - 1'b1);
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_r        <= 1'b0;
			sh_r          <= 72'h0;
			left_r        <= 7'h0;
			btmr_r        <= 6'h0;
			lpd_data_r    <= 4'h0;
			lpd_data_oe_r <= 1'b0;
			lpd_dio_r     <= 1'b0;
			lpd_dio_oe_r  <= 1'b0;
		end else begin
			busy_r        <= busy_nxt;
			sh_r          <= sh_nxt;
			left_r        <= left_nxt;
			btmr_r        <= btmr_nxt;
			lpd_data_r    <= data_nxt;
			lpd_data_oe_r <= data_oe_nxt;
			lpd_dio_r     <= dio_nxt;
			lpd_dio_oe_r  <= dio_oe_nxt;
		end
	end

	// access break timing: data-qualified waits for the instruction to finish
	logic pend_r, pend_nxt, before_nxt, after_nxt, qual_hit;
	always_comb begin
		qual_hit   = brk_in.hit && brk_in.data_qual;
		before_nxt = brk_in.hit && !brk_in.data_qual;
		after_nxt  = (pend_r || qual_hit) && brk_in.instr_done;
		pend_nxt   = (pend_r || qual_hit) && !brk_in.instr_done;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_r         <= 1'b0;
			break_before_r <= 1'b0;
			break_after_r  <= 1'b0;
		end else begin
			pend_r         <= pend_nxt;
			break_before_r <= before_nxt;
			break_after_r  <= after_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_quiet_no_probe: assert property (!link_on |=> !lpd_data_oe_r && !lpd_dio_oe_r && !busy_r)
		else $error("link pins driven without a probe");
	a_pc_record: assert property (st_r == st_idle && trace_ready_r && trace_req.valid &&
		trace_req.kind == trace_pkg::kind_pc && link_on && fill < trace_pkg::BUF_OVF_AT
		|=> push_r && push_rec_r.kind == trace_pkg::kind_pc && push_rec_r.pc == $past(trace_req.pc))
		else $error("pc record not pushed");
	a_tag_value: assert property (push_r && push_rec_r.kind == trace_pkg::kind_tag
		|-> push_rec_r.value == {22'h0, $past(trace_req.tag_immediate)})
		else $error("tag record holds more than ten bits");
	a_dump_ascend: assert property (st_r == st_dump && reg_rd_idx_r < last_r
		|=> reg_rd_idx_r == $past(reg_rd_idx_r) + 5'h1 && st_r == st_dump)
		else $error("register dump not ascending");
	a_ovf_marker: assert property (cand_ok && link_on && fill == trace_pkg::BUF_OVF_AT
		|=> push_r && push_rec_r.kind == trace_pkg::kind_ovf && trace_lost_r)
		else $error("overflow marker missing at eighth stage");
	a_full_drop: assert property (cand_ok && link_on && fill > trace_pkg::BUF_OVF_AT
		|=> !push_r && trace_lost_r)
		else $error("record pushed into a full buffer");
	a_tag_short: assert property (buf_pop && buf_out.kind == trace_pkg::kind_tag && !buf_out.with_pc
		|=> left_r == 7'd19)
		else $error("tag frame length wrong");
	a_nibble_count: assert property (buf_pop && !one_pin && buf_out.kind == trace_pkg::kind_pc
		|=> left_r == 7'd57)
		else $error("four pin pc frame length wrong");
	a_break_after: assert property (qual_hit && !brk_in.instr_done && !pend_r
		|=> !break_after_r ##0 (pend_r throughout (!brk_in.instr_done [*1])))
		else $error("data break fired before instruction end");
	a_break_before: assert property (brk_in.hit && !brk_in.data_qual |=> break_before_r)
		else $error("access break not taken before instruction");
	a_sel_hold: assert property (sel_done_r |=> sel_r == $past(sel_r))
		else $error("interface select changed after capture");

	c_pc_sent: cover property (buf_pop && buf_out.kind == trace_pkg::kind_pc);
	c_dump_three: cover property (st_r == st_dump [*3]);
	c_overflow: cover property (push_r && push_rec_r.kind == trace_pkg::kind_ovf);
	c_one_pin: cover property (lpd_dio_oe_r && one_pin);

endmodule
`default_nettype wire

/* File: test/lpd_probe_model.sv */
// behavioural debug probe: presence pin, link clock and frame capture
// assumes the port's link pins and the bench's core clock
`timescale 1ns/100ps
`default_nettype none
module lpd_probe_model (
	input  wire logic       clk,
	input  wire logic       attach,
	input  wire logic [3:0] lpd_data_r,
	input  wire logic       lpd_data_oe_r,
	input  wire logic       lpd_dio_r,
	input  wire logic       lpd_dio_oe_r,
	output logic            probe_present,
	output logic            link_clk
);
	logic [303:0] fr = '0;
	int           syms = 0;
	int           cyc = 0;
	int           ph = 0;
	int           w = 1;
	logic [303:0] bits_q[$];
	int           syms_q[$];
	int           cyc_q[$];
	logic [31:0]  ram[16];

	// target ram wiped on every attach so no ecc noise from stale cells
	always @(posedge attach) begin
		foreach (ram[i]) ram[i] = 32'h0;
	end

	// presence pin follows the attach request
	assign probe_present = attach;

	// link clock runs only while attached; the port needs it to shift four-pin nibbles
	initial begin
		link_clk = 1'b0;
		#3;
		forever #80 link_clk = attach & ~link_clk;
	end

	// four-pin nibbles taken halfway through each link clock
	always @(negedge link_clk) begin
		if (lpd_data_oe_r === 1'b1) begin
			fr = {fr[299:0], lpd_data_r};
			syms = syms + 1;
			w = 4;
		end
	end

	// one-pin bits taken mid bit; a frame closes once both enables drop
	always @(posedge clk) begin
		if (lpd_dio_oe_r === 1'b1 || lpd_data_oe_r === 1'b1) begin
			if (lpd_dio_oe_r === 1'b1 && ph == 31) begin
				fr = {fr[302:0], lpd_dio_r};
				syms = syms + 1;
				w = 1;
			end
			ph = (ph == 61) ? 0 : ph + 1;
			cyc = cyc + 1;
		end else if (cyc > 0) begin
			bits_q.push_back(fr << (304 - syms * w));
			syms_q.push_back(syms);
			cyc_q.push_back(cyc);
			fr = '0;
			syms = 0;
			cyc = 0;
			ph = 0;
		end
	end

	// drop whatever was captured
	task automatic flush();
		bits_q.delete();
		syms_q.delete();
		cyc_q.delete();
	endtask
endmodule
`default_nettype wire

/* File: test/test_sw_trace_port.sv */
// self-checking bench for the software trace debug port
// assumes the port, its fifo and the probe model are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_sw_trace_port;
	localparam int LIMIT = 60000;
	logic                     clk = 1'b0;
	logic                     nrst = 1'b0;
	trace_pkg::trace_req_type trace_req = '0;
	trace_pkg::brk_in_type    brk_in = '0;
	logic [31:0]              option_word_zero = 32'h0;
	logic                     attach = 1'b0;
	logic [31:0]              rf[32];
	logic [31:0]              rnd = 32'h401B;
	logic [31:0]              reg_rd_data;
	logic                     trace_ready_r, lpd_data_oe_r, lpd_dio_r, lpd_dio_oe_r;
	logic                     trace_lost_r, break_before_r, break_after_r;
	logic                     probe_present, link_clk;
	logic [4:0]               reg_rd_idx_r;
	logic [3:0]               lpd_data_r;
	int                       mismatches = 0;
	int                       n_tests = 0;
	int                       cycles = 0;
	int                       lost = 0;
	int                       oe4 = 0;
	int                       oe1 = 0;

	// core clock and register file read port
	always #4 clk = ~clk;
	assign reg_rd_data = rf[reg_rd_idx_r];

	sw_trace_port i_sw_trace_port (
		.clk(clk), .nrst(nrst), .trace_req(trace_req), .trace_ready_r(trace_ready_r),
		.reg_rd_idx_r(reg_rd_idx_r), .reg_rd_data(reg_rd_data),
		.option_word_zero(option_word_zero), .probe_present(probe_present),
		.link_clk(link_clk), .lpd_data_r(lpd_data_r), .lpd_data_oe_r(lpd_data_oe_r),
		.lpd_dio_r(lpd_dio_r), .lpd_dio_oe_r(lpd_dio_oe_r), .trace_lost_r(trace_lost_r),
		.brk_in(brk_in), .break_before_r(break_before_r), .break_after_r(break_after_r)
	);
	lpd_probe_model i_lpd_probe_model (
		.clk(clk), .attach(attach), .lpd_data_r(lpd_data_r), .lpd_data_oe_r(lpd_data_oe_r),
		.lpd_dio_r(lpd_dio_r), .lpd_dio_oe_r(lpd_dio_oe_r),
		.probe_present(probe_present), .link_clk(link_clk)
	);

	// lfsr step from the fixed seed
	function automatic logic [31:0] roll();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction

	task automatic end_of_test();
		if (mismatches == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// monitors: loss pulses, enable activity, hang limit
	always @(posedge clk) begin
		cycles++;
		if (trace_lost_r === 1'b1) lost++;
		if (lpd_data_oe_r === 1'b1) oe4++;
		if (lpd_dio_oe_r === 1'b1) oe1++;
		if (cycles == LIMIT) begin
			mismatches++;
			end_of_test();
		end
	end

	// reset with a link select in option word zero; select is never rewritten later
	task automatic do_reset(input logic [1:0] sel);
		logic [31:0] w;
		w = roll();
		@(negedge clk);
		nrst = 1'b0;
		option_word_zero = {w[31], sel, w[28:0]};
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (10) @(negedge clk);
		i_lpd_probe_model.flush();
		lost = 0;
		oe4 = 0;
		oe1 = 0;
	endtask

	// only trace kinds are issued, never a soft break trap
	task automatic issue(input trace_pkg::rec_kind_type k, input logic wp,
			input logic [31:0] pc, input logic [9:0] imm, input logic [4:0] f, input logic [4:0] l);
		int t;
		t = 0;
		while (trace_ready_r !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		trace_req = '{1'b1, k, wp, pc, imm, f, l};
		@(negedge clk);
	endtask

	task automatic chk_frame(input logic [1:0] k, input logic [4:0] rn, input logic [31:0] v,
			input logic [31:0] m, input int ns, input logic one);
		logic [303:0] fr;
		int           t;
		t = 0;
		while (i_lpd_probe_model.bits_q.size() == 0 && t < 12000) begin
			@(negedge clk);
			t++;
		end
		if (i_lpd_probe_model.bits_q.size() == 0) begin
			check("frame", 32'h0, 32'h1);
			return;
		end
		fr = i_lpd_probe_model.bits_q.pop_front();
		t = i_lpd_probe_model.cyc_q.pop_front();
		check("kind", fr[303:302], k);
		if (k == 2'h2) check("reg num", fr[300:296], rn);
		check("body", fr[295:264] & m, v & m);
		check("symbols", i_lpd_probe_model.syms_q.pop_front(), ns);
		if (one) check("bit time", (t + 31) / 62, ns);
	endtask

	task automatic brk_once(input logic qual, input int d);
		brk_in = '{1'b1, qual, 1'b0};
		@(negedge clk);
		brk_in = '0;
		check("break before", break_before_r, !qual);
		repeat (d) begin
			check("break early", break_after_r, 1'b0);
			@(negedge clk);
		end
		brk_in = '{1'b0, 1'b0, 1'b1};
		@(negedge clk);
		brk_in = '0;
		check("break after", break_after_r, qual);
		@(negedge clk);
	endtask

	// main sequence: scan, absent probe, four-pin, overflow, breaks, one-pin
	initial begin
		logic [31:0] p;
		logic [31:0] pcs[12];
		logic [9:0]  imm;
		int          n, f, l, lo;
		int          tab[6] = '{3, 5, 7, 7, 9, 4}; // dumps of fewer than 5 registers
		for (int i = 0; i < 32; i++) rf[i] = roll();
		attach = 1'b1;
		do_reset(trace_pkg::SEL_SCAN);
		issue(trace_pkg::kind_pc, 1'b0, roll(), 10'h0, 5'h0, 5'h0);
		trace_req.valid = 1'b0;
		repeat (400) @(negedge clk);
		check("scan oe", oe4 + oe1, 0);
		attach = 1'b0;
		do_reset(trace_pkg::SEL_FOUR);
		issue(trace_pkg::kind_tag, 1'b1, roll(), 10'h155, 5'h0, 5'h0);
		trace_req.valid = 1'b0;
		repeat (300) @(negedge clk);
		check("absent oe", oe4 + oe1, 0);
		attach = 1'b1;
		repeat (600) @(negedge clk);
		check("late frames", i_lpd_probe_model.bits_q.size(), 0);
		check("ram clear", i_lpd_probe_model.ram[3], 32'h0);
		p = roll();
		imm = p[21:12];
		p = roll();
		issue(trace_pkg::kind_pc, 1'b0, p, 10'h0, 5'h0, 5'h0);
		issue(trace_pkg::kind_tag, 1'b0, p, imm, 5'h0, 5'h0);
		issue(trace_pkg::kind_tag, 1'b1, p, imm, 5'h0, 5'h0);
		trace_req.valid = 1'b0;
		chk_frame(2'h0, 5'h0, p, 32'hFFFFFFFF, 57, 1'b0);
		chk_frame(2'h1, 5'h0, {imm, 22'h0}, 32'hFFC00000, 19, 1'b0);
		chk_frame(2'h1, 5'h0, {imm, p[31:10]}, 32'hFFFFFFFF, 57, 1'b0);
		for (int d = 0; d < 3; d++) begin
			f = tab[2 * d];
			l = tab[2 * d + 1];
			n = (l >= f) ? l - f + 1 : 1;
			issue(trace_pkg::kind_regs, d[0], roll(), 10'h0, f[4:0], l[4:0]);
			trace_req.valid = 1'b0;
			lo = 0;
			repeat (n + 3) begin
				if (trace_ready_r === 1'b0) lo++;
				@(negedge clk);
			end
			check("dump busy", lo, n);
			for (int r = 0; r < n; r++) chk_frame(2'h2, 5'(f + r), rf[f + r], 32'hFFFFFFFF, 57, 1'b0);
		end
		for (int i = 0; i < 12; i++) begin
			pcs[i] = roll();
			issue(trace_pkg::kind_pc, 1'b0, pcs[i], 10'h0, 5'h0, 5'h0);
		end
		trace_req.valid = 1'b0;
		repeat (11000) @(negedge clk);
		n = i_lpd_probe_model.bits_q.size();
		check("stages", (n == 8 || n == 9), 1'b1);
		check("lost", lost, 13 - n);
		for (int i = 0; i < n - 1; i++) chk_frame(2'h0, 5'h0, pcs[i], 32'hFFFFFFFF, 57, 1'b0);
		chk_frame(2'h3, 5'h0, 32'h0, 32'h0, 19, 1'b0);
		for (int i = 0; i < 6; i++) begin
			p = roll();
			brk_once(i[0], 1 + int'(p[2:1]));
		end
		do_reset(trace_pkg::SEL_ONE);
		p = roll();
		issue(trace_pkg::kind_pc, 1'b0, p, 10'h0, 5'h0, 5'h0);
		issue(trace_pkg::kind_tag, 1'b0, p, imm, 5'h0, 5'h0);
		issue(trace_pkg::kind_regs, 1'b0, p, 10'h0, 5'h6, 5'h6);
		trace_req.valid = 1'b0;
		@(negedge clk);
		issue(trace_pkg::kind_regs, 1'b1, p, 10'h0, 5'h8, 5'h8);
		trace_req.valid = 1'b0;
		chk_frame(2'h0, 5'h0, p, 32'hFFFFFFFF, 57, 1'b1);
		chk_frame(2'h1, 5'h0, {imm, 22'h0}, 32'hFFC00000, 19, 1'b1);
		chk_frame(2'h2, 5'h6, rf[6], 32'hFFFFFFFF, 57, 1'b1);
		chk_frame(2'h2, 5'h8, rf[8], 32'hFFFFFFFF, 76, 1'b1);
		check("one-pin nibble oe", oe4, 0);
		end_of_test();
	end
endmodule
`default_nettype wire
